/* rtl/eepa_consts.svh */
// address map, field positions, reset values of the eeprom program/erase ctrl
`ifndef EEPA_CONSTS_SVH
`define EEPA_CONSTS_SVH

`define EEPA_ARR_BASE 16'h0800
`define EEPA_ARR_LAST 16'h09ff
`define EEPA_SEC_FIRST 16'h08f0
`define EEPA_SEC_LAST 16'h08ff
`define EEPA_NVR_ADDR 16'hfe10
`define EEPA_IDX_W 9
`define EEPA_DEPTH 512
`define EEPA_BLK_HI 8
`define EEPA_BLK_LO 7
`define EEPA_NVR_SEC_BIT 4
`define EEPA_NVR_BP_HI 3
`define EEPA_NVR_DELIVERED 8'h10
`define EEPA_VCFG_RST 8'h0f
`define EEPA_ERASED 8'hff
`define EEPA_RD_NONE 8'h00

`endif

/* rtl/eepa_pkg.sv */
// types shared by the eeprom program/erase controller files
package eepa_pkg;

	typedef enum logic [1:0] {
		EEPA_M_PROG = 2'b00,
		EEPA_M_BYTE_ERASE = 2'b01,
		EEPA_M_BLOCK_ERASE = 2'b10,
		EEPA_M_BULK_ERASE = 2'b11
	} eepa_mode_t;

	typedef struct packed {
		logic erase_sel_hi;
		logic erase_sel_lo;
		logic latch_bit;
		logic program_enable;
	} eepa_ctl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} eepa_bus_t;

endpackage : eepa_pkg

/* rtl/eepa_rst_sync.sv */
// reset release synchroniser
module eepa_rst_sync (
	// clock and raw reset
	input wire logic clk,
	input wire logic rst_b,
	// synchronised reset
	output logic rst_sync_b
);
	logic meta_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			meta_r <= 1'b1;
			rst_sync_b <= meta_r;
		end
	end
endmodule : eepa_rst_sync

/* rtl/eepa_array.sv */
// nonvolatile storage: 512 array bytes plus the config byte
`include "eepa_consts.svh"
module eepa_array (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// operation commit
	input wire logic op_go,
	input wire eepa_pkg::eepa_mode_t op_mode,
	input wire logic op_nvr,
	input wire logic [`EEPA_IDX_W-1:0] op_idx,
	input wire logic [7:0] op_data,
	// read side
	input wire logic [`EEPA_IDX_W-1:0] rd_idx,
	output logic [7:0] rd_data,
	output logic [7:0] nvr_q
);
	// nonvolatile: no reset; the delivered image stands in for the factory
	logic [7:0] mem_r [0:`EEPA_DEPTH-1] = '{default: `EEPA_ERASED};
	logic [7:0] nvr_r = `EEPA_NVR_DELIVERED;
	logic [7:0] past_byte_r;

	always_ff @(posedge clk) begin
		if (op_go && !op_nvr) begin
			unique case (op_mode)
				eepa_pkg::EEPA_M_PROG:
					mem_r[op_idx] <= mem_r[op_idx] & op_data;
				eepa_pkg::EEPA_M_BYTE_ERASE:
					mem_r[op_idx] <= `EEPA_ERASED;
				eepa_pkg::EEPA_M_BLOCK_ERASE: begin
					for (int i = 0; i < `EEPA_DEPTH; i++) begin
						if (i[`EEPA_BLK_HI:`EEPA_BLK_LO] ==
						    op_idx[`EEPA_BLK_HI:`EEPA_BLK_LO]) begin
							mem_r[i] <= `EEPA_ERASED;
						end
					end
				end
				eepa_pkg::EEPA_M_BULK_ERASE: begin
					for (int i = 0; i < `EEPA_DEPTH; i++) begin
						mem_r[i] <= `EEPA_ERASED;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (op_go && op_nvr) begin
			if (op_mode == eepa_pkg::EEPA_M_PROG) begin
				nvr_r <= nvr_r & op_data;
			end else begin
				nvr_r <= `EEPA_ERASED;
			end
		end
	end

	always_ff @(posedge clk) begin
		past_byte_r <= mem_r[op_idx];
	end

	assign rd_data = mem_r[rd_idx];
	assign nvr_q = nvr_r;

	property p_prog_only_clears;
		@(posedge clk) disable iff (!rst_b)
		(op_go && !op_nvr && op_mode == eepa_pkg::EEPA_M_PROG)
		|=> ((mem_r[$past(op_idx)] & ~past_byte_r) == 8'h00);
	endproperty
	a_prog_only_clears: assert property (p_prog_only_clears)
		else $error("program set a bit from 0 to 1");

	property p_bulk_nvr_kept;
		@(posedge clk) disable iff (!rst_b)
		(op_go && !op_nvr) |=> (nvr_r == $past(nvr_r));
	endproperty
	a_bulk_nvr_kept: assert property (p_bulk_nvr_kept)
		else $error("array operation altered the config byte");
endmodule : eepa_array

/* rtl/eepa_ctrl.sv */
// eeprom program/erase controller top: control bits, latches, interlocks
// Functional notes
// - 512-byte array at 0800h to 09FFh
// - erased reads 1; program only clears bits
// - operations only on unprotected bytes, config byte
// - latch captures writes; refuse control until valid
// - no enable after stray write, latch clear
// - enable drives pump and high voltage
// - erase mode frozen while enable set
// - clearing both bits clears enable only
// - block/bulk erase; config byte untouched
// - protected block not erased; bulk blocked
// - four 128-byte blocks, bit 0 lowest
// - protected target never gets high voltage
// - reset and config read reload volatile copy
// - config byte programmed/erased like array byte
// - delivered erased, security bit 1
// - security blocks 08F0h to 08FFh
// - security: no block/bulk, config locked
// - secured writes are not valid writes
// - security permanent, config frozen
// - erase-select decode; protect stops all
// - latch cannot clear while enable set
`include "eepa_consts.svh"
module eepa_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// cpu bus access to the array and config byte
	input wire eepa_pkg::eepa_bus_t bus_req,
	output logic [7:0] rdata_r,
	// array_control_reg write strobe and contents
	input wire logic ctl_wr,
	input wire eepa_pkg::eepa_ctl_t ctl_wdata,
	output eepa_pkg::eepa_ctl_t ctl_q,
	output logic ctl_refused_r,
	// status
	output logic hv_on_r,
	output logic [7:0] volatile_config_reg,
	output logic secured
);
	logic rst_s_b;
	eepa_pkg::eepa_ctl_t ctl_r;
	logic lat_valid_r;
	logic stray_wr_r;
	logic [15:0] lat_addr_r;
	logic [7:0] lat_data_r;
	logic [7:0] vcfg_r;
	logic cfg_loaded_r;
	logic [7:0] nvr_q;
	logic [7:0] arr_rd;
	logic in_arr;
	logic is_nvr;
	logic valid_wr;
	logic refuse;
	logic op_ok;
	logic op_go;
	logic lat_nvr;
	eepa_pkg::eepa_mode_t mode;

	function automatic logic eepa_in_array(input logic [15:0] a);
		return (a >= `EEPA_ARR_BASE) && (a <= `EEPA_ARR_LAST);
	endfunction : eepa_in_array

	function automatic logic eepa_secure_loc(input logic [15:0] a);
		return (a >= `EEPA_SEC_FIRST) && (a <= `EEPA_SEC_LAST);
	endfunction : eepa_secure_loc

	function automatic logic [`EEPA_IDX_W-1:0] eepa_idx(
		input logic [15:0] a);
		return a[`EEPA_IDX_W-1:0];
	endfunction : eepa_idx

	function automatic logic eepa_op_allowed(
		input eepa_pkg::eepa_mode_t m,
		input logic [15:0] a,
		input logic [7:0] cfg,
		input logic sec);
		logic [`EEPA_IDX_W-1:0] idx;
		logic [`EEPA_NVR_BP_HI:0] bp;
		logic blk_bp;
		logic ok;
		idx = eepa_idx(a);
		bp = cfg[`EEPA_NVR_BP_HI:0];
		blk_bp = bp[idx[`EEPA_BLK_HI:`EEPA_BLK_LO]];
		ok = 1'b0;
		if (a == `EEPA_NVR_ADDR) begin
			// config byte: only byte ops, and never once secured
			ok = !sec && (m == eepa_pkg::EEPA_M_PROG ||
			              m == eepa_pkg::EEPA_M_BYTE_ERASE);
		end else if (eepa_in_array(a)) begin
			unique case (m)
				eepa_pkg::EEPA_M_PROG,
				eepa_pkg::EEPA_M_BYTE_ERASE:
					ok = !blk_bp && !(sec && eepa_secure_loc(a));
				eepa_pkg::EEPA_M_BLOCK_ERASE:
					ok = !blk_bp && !sec;
				eepa_pkg::EEPA_M_BULK_ERASE:
					ok = (bp == '0) && !sec;
			endcase
		end
		return ok;
	endfunction : eepa_op_allowed

	eepa_rst_sync u_rst_sync (
		.clk(clk),
		.rst_b(rst_b),
		.rst_sync_b(rst_s_b)
	);

	// decode of the current bus cycle
	assign in_arr = eepa_in_array(bus_req.addr);
	assign is_nvr = (bus_req.addr == `EEPA_NVR_ADDR);
	assign secured = !nvr_q[`EEPA_NVR_SEC_BIT];
	assign valid_wr = bus_req.wr && (is_nvr || (in_arr &&
	                  !(secured && eepa_secure_loc(bus_req.addr))));
	assign mode = eepa_pkg::eepa_mode_t'({ctl_r.erase_sel_hi,
	                                      ctl_r.erase_sel_lo});
	assign refuse = ctl_r.latch_bit && !lat_valid_r;
	assign lat_nvr = (lat_addr_r == `EEPA_NVR_ADDR);
	assign op_ok = eepa_op_allowed(mode, lat_addr_r, vcfg_r, secured);
	// commit in the cycle after enable drops with voltage still applied
	assign op_go = hv_on_r && !ctl_r.program_enable;
	assign ctl_q = ctl_r;
	assign volatile_config_reg = vcfg_r;

	// array_control_reg
	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			ctl_r <= '0;
		end else if (ctl_wr && !refuse) begin
			if (ctl_r.program_enable) begin
				// mode held while pumping
				ctl_r.erase_sel_hi <= ctl_r.erase_sel_hi;
				ctl_r.erase_sel_lo <= ctl_r.erase_sel_lo;
			end else begin
				ctl_r.erase_sel_hi <= ctl_wdata.erase_sel_hi;
				ctl_r.erase_sel_lo <= ctl_wdata.erase_sel_lo;
			end
			if (ctl_r.program_enable && !ctl_wdata.latch_bit) begin
				// voltage must decay before buses return to read
				ctl_r.latch_bit <= 1'b1;
			end else begin
				ctl_r.latch_bit <= ctl_wdata.latch_bit;
			end
			if (ctl_wdata.program_enable && !ctl_r.program_enable &&
			    !ctl_r.latch_bit && stray_wr_r) begin
				ctl_r.program_enable <= 1'b0;
			end else begin
				ctl_r.program_enable <= ctl_wdata.program_enable;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			ctl_refused_r <= 1'b0;
		end else begin
			ctl_refused_r <= ctl_wr && refuse;
		end
	end

	// stray write tracking for the enable interlock
	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			stray_wr_r <= 1'b0;
		end else if (bus_req.wr && !valid_wr && !ctl_r.latch_bit) begin
			stray_wr_r <= 1'b1;
		end else if (ctl_r.latch_bit) begin
			stray_wr_r <= 1'b0;
		end
	end

	// address and data latch
	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			lat_valid_r <= 1'b0;
			lat_addr_r <= 16'h0000;
			lat_data_r <= 8'h00;
		end else if (!ctl_r.latch_bit) begin
			lat_valid_r <= 1'b0;
		end else if (valid_wr) begin
			// a later valid write overrides the earlier one
			lat_valid_r <= 1'b1;
			lat_addr_r <= bus_req.addr;
			lat_data_r <= bus_req.wdata;
		end
	end

	// charge pump and high voltage
	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			hv_on_r <= 1'b0;
		end else begin
			hv_on_r <= ctl_r.program_enable && ctl_r.latch_bit &&
			           lat_valid_r && op_ok;
		end
	end

	// volatile copy of the config byte
	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			cfg_loaded_r <= 1'b0;
			vcfg_r <= `EEPA_VCFG_RST;
		end else if (!cfg_loaded_r || (bus_req.rd && is_nvr)) begin
			cfg_loaded_r <= 1'b1;
			vcfg_r <= nvr_q;
		end
	end

	// read data, one cycle after the read strobe
	always_ff @(posedge clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			rdata_r <= `EEPA_RD_NONE;
		end else if (bus_req.rd) begin
			if (is_nvr) begin
				rdata_r <= nvr_q;
			end else if (in_arr && ctl_r.latch_bit && lat_valid_r) begin
				rdata_r <= lat_data_r;
			end else if (in_arr) begin
				rdata_r <= arr_rd;
			end else begin
				rdata_r <= `EEPA_RD_NONE;
			end
		end
	end

	eepa_array u_array (
		.clk(clk),
		.rst_b(rst_s_b),
		.op_go(op_go),
		.op_mode(mode),
		.op_nvr(lat_nvr),
		.op_idx(eepa_idx(lat_addr_r)),
		.op_data(lat_data_r),
		.rd_idx(eepa_idx(bus_req.addr)),
		.rd_data(arr_rd),
		.nvr_q(nvr_q)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s_b);

	sequence s_refused_write;
		ctl_wr && ctl_r.latch_bit && !lat_valid_r;
	endsequence

	sequence s_enable_dropped;
		hv_on_r && !ctl_r.program_enable;
	endsequence

	property p_refuse_ctl;
		s_refused_write |=> $stable(ctl_r) && ctl_refused_r;
	endproperty
	a_refuse_ctl: assert property (p_refuse_ctl)
		else $error("control write taken before a valid array write");

	property p_capture;
		(ctl_r.latch_bit && valid_wr) |=>
			lat_valid_r && lat_addr_r == $past(bus_req.addr) &&
			lat_data_r == $past(bus_req.wdata);
	endproperty
	a_capture: assert property (p_capture)
		else $error("valid write not latched");

	property p_stray_block;
		(ctl_wr && !refuse && ctl_wdata.program_enable &&
		 !ctl_r.program_enable && !ctl_r.latch_bit && stray_wr_r)
		|=> !ctl_r.program_enable;
	endproperty
	a_stray_block: assert property (p_stray_block)
		else $error("enable set after a stray write");

	property p_mode_hold;
		ctl_r.program_enable |=> $past(mode) == mode;
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("erase mode changed while enabled");

	property p_latch_keep;
		ctl_r.program_enable |=> ctl_r.latch_bit;
	endproperty
	a_latch_keep: assert property (p_latch_keep)
		else $error("latch cleared while enable was set");

	property p_hv_follow;
		(ctl_r.program_enable && ctl_r.latch_bit && lat_valid_r && op_ok)
		|=> hv_on_r;
	endproperty
	a_hv_follow: assert property (p_hv_follow)
		else $error("high voltage not applied");

	property p_hv_drop;
		s_enable_dropped |=> !hv_on_r ##1 !hv_on_r || ctl_r.program_enable;
	endproperty
	a_hv_drop: assert property (p_hv_drop)
		else $error("high voltage stayed on after enable cleared");

	property p_hv_protect;
		hv_on_r |-> $past(op_ok) && !(secured && !lat_nvr &&
		                             eepa_secure_loc(lat_addr_r));
	endproperty
	a_hv_protect: assert property (p_hv_protect)
		else $error("high voltage on a protected target");

	property p_cfg_reload;
		(bus_req.rd && is_nvr) |=> vcfg_r == $past(nvr_q);
	endproperty
	a_cfg_reload: assert property (p_cfg_reload)
		else $error("volatile config not reloaded on read");

	property p_secure_not_valid;
		(secured && bus_req.wr && eepa_secure_loc(bus_req.addr))
		|-> !valid_wr;
	endproperty
	a_secure_not_valid: assert property (p_secure_not_valid)
		else $error("secured location counted as a valid write");
endmodule : eepa_ctrl

/* dv/eepa_cpu_model.sv */
// cpu model: drives the bus and control strobes of the eeprom controller
module eepa_cpu_model #(
	parameter int T_PGM = 6,
	parameter int T_FALL = 3
) (
	// clock and voltage status
	input wire logic clk,
	input wire logic hv_on_r,
	// requests to the controller
	output eepa_pkg::eepa_bus_t bus_req,
	output logic ctl_wr,
	output eepa_pkg::eepa_ctl_t ctl_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus_req = '0;
		ctl_wr = 1'b0;
		ctl_wdata = '0;
	end
	// released lines show the inverse so a stale value is never trusted
	task automatic ctl(input logic [3:0] v);
		@(negedge clk);
		ctl_wdata = v;
		ctl_wr = 1'b1;
		@(negedge clk);
		ctl_wr = 1'b0;
		ctl_wdata = ~v;
	endtask : ctl
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge clk);
		bus_req = {w, ~w, a, d};
		@(negedge clk);
		bus_req = {2'b00, ~a, ~d};
	endtask : acc
	// one whole program or erase pass; hv tells whether voltage showed
	task automatic op(input logic [1:0] m, input logic [15:0] a,
		input logic [7:0] d, output logic hv);
		hv = 1'b0;
		ctl({m, 2'b10});
		acc(1'b1, a, d);
		ctl({m, 2'b11});
		repeat (T_PGM) begin
			@(negedge clk);
			hv = hv | hv_on_r;
		end
		ctl({m, 2'b10});
		repeat (T_FALL) @(negedge clk);
		ctl(4'h0);
	endtask : op
endmodule : eepa_cpu_model

/* dv/eeprom_program_erase_ctrl_test.sv */
// self-checking bench for the eeprom program/erase controller
module eeprom_program_erase_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst_b;
	eepa_pkg::eepa_bus_t bus_req;
	logic ctl_wr;
	eepa_pkg::eepa_ctl_t ctl_wdata;
	eepa_pkg::eepa_ctl_t ctl_q;
	logic [7:0] rdata_r;
	logic ctl_refused_r;
	logic hv_on_r;
	logic [7:0] volatile_config_reg;
	logic secured;
	logic hv;
	int fail_count = 0;
	int checks_done = 0;

	eepa_ctrl eepa_ctrl_i (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
		.rdata_r(rdata_r), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
		.ctl_q(ctl_q), .ctl_refused_r(ctl_refused_r), .hv_on_r(hv_on_r),
		.volatile_config_reg(volatile_config_reg), .secured(secured));
	eepa_cpu_model eepa_cpu_model_i (.clk(clk), .hv_on_r(hv_on_r),
		.bus_req(bus_req), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask : chk
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		eepa_cpu_model_i.acc(1'b0, a, 8'h00);
		chk(rdata_r, e);
	endtask : rd
	task automatic op(input logic [1:0] m, input logic [15:0] a,
		input logic [7:0] d);
		eepa_cpu_model_i.op(m, a, d, hv);
	endtask : op
	task automatic do_reset;
		@(negedge clk);
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
	endtask : do_reset
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic t_reset;
		chk({4'h0, ctl_q}, 8'h00);
		chk({7'h00, hv_on_r}, 8'h00);
		chk(volatile_config_reg, 8'h10);
		chk({7'h00, secured}, 8'h00);
		rd(16'h0800, 8'hff);
		rd(16'h09ff, 8'hff);
		$display("test reset done");
	endtask : t_reset
	task automatic t_program;
		op(2'b00, 16'h0810, 8'h5a);
		chk({7'h00, hv}, 8'h01);
		rd(16'h0810, 8'h5a);
		op(2'b00, 16'h0810, 8'ha5);
		rd(16'h0810, 8'h00);
		op(2'b01, 16'h0810, 8'h00);
		rd(16'h0810, 8'hff);
		$display("test program done");
	endtask : t_program
	task automatic t_latch;
		eepa_cpu_model_i.ctl(4'h2);
		eepa_cpu_model_i.ctl(4'h3);
		chk({7'h00, ctl_refused_r}, 8'h01);
		chk({4'h0, ctl_q}, 8'h02);
		eepa_cpu_model_i.acc(1'b1, 16'h0820, 8'hc3);
		eepa_cpu_model_i.acc(1'b1, 16'h0830, 8'h00);
		rd(16'h0900, 8'h00);
		eepa_cpu_model_i.ctl(4'h3);
		chk({4'h0, ctl_q}, 8'h03);
		eepa_cpu_model_i.ctl(4'hf);
		chk({4'h0, ctl_q}, 8'h03);
		eepa_cpu_model_i.ctl(4'h0);
		chk({4'h0, ctl_q}, 8'h02);
		eepa_cpu_model_i.ctl(4'h0);
		rd(16'h0830, 8'h00);
		rd(16'h0820, 8'hff);
		eepa_cpu_model_i.acc(1'b1, 16'h0400, 8'h00);
		eepa_cpu_model_i.ctl(4'h1);
		chk({4'h0, ctl_q}, 8'h00);
		$display("test latch done");
	endtask : t_latch
	task automatic t_erase;
		op(2'b00, 16'h0880, 8'h3c);
		op(2'b10, 16'h0855, 8'h00);
		rd(16'h0830, 8'hff);
		rd(16'h0880, 8'h3c);
		op(2'b11, 16'h0900, 8'h00);
		rd(16'h0880, 8'hff);
		rd(16'h0830, 8'hff);
		rd(16'hfe10, 8'h10);
		$display("test erase done");
	endtask : t_erase
	task automatic t_protect;
		op(2'b01, 16'hfe10, 8'h00);
		rd(16'hfe10, 8'hff);
		op(2'b00, 16'hfe10, 8'h12);
		chk(volatile_config_reg, 8'hff);
		eepa_cpu_model_i.acc(1'b0, 16'h0000, 8'h00);
		eepa_cpu_model_i.acc(1'b0, 16'h0000, 8'h00);
		rd(16'hfe10, 8'h12);
		chk(volatile_config_reg, 8'h12);
		op(2'b00, 16'h0880, 8'h00);
		chk({7'h00, hv}, 8'h00);
		rd(16'h0880, 8'hff);
		op(2'b11, 16'h0900, 8'h00);
		chk({7'h00, hv}, 8'h00);
		op(2'b00, 16'h0800, 8'h0f);
		rd(16'h0800, 8'h0f);
		$display("test protect done");
	endtask : t_protect
	task automatic t_secure;
		op(2'b00, 16'hfe10, 8'h00);
		chk({7'h00, secured}, 8'h01);
		rd(16'hfe10, 8'h00);
		chk(volatile_config_reg, 8'h00);
		op(2'b00, 16'h08f0, 8'h00);
		chk({7'h00, hv}, 8'h00);
		chk({7'h00, ctl_refused_r}, 8'h01);
		eepa_cpu_model_i.acc(1'b1, 16'h0800, 8'hff);
		eepa_cpu_model_i.ctl(4'h0);
		rd(16'h08f0, 8'hff);
		op(2'b01, 16'h0800, 8'h00);
		rd(16'h0800, 8'hff);
		op(2'b10, 16'h0800, 8'h00);
		chk({7'h00, hv}, 8'h00);
		op(2'b01, 16'hfe10, 8'h00);
		rd(16'hfe10, 8'h00);
		do_reset();
		chk(volatile_config_reg, 8'h00);
		chk({4'h0, ctl_q}, 8'h00);
		$display("test secure done");
	endtask : t_secure

	initial begin
		rst_b = 1'b0;
		do_reset();
		t_reset();
		t_program();
		t_latch();
		t_erase();
		t_protect();
		t_secure();
		final_report();
	end
	// whole run needs about four hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end
endmodule : eeprom_program_erase_ctrl_test
